// *** design/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_REG_ADDR     = 8'hC5;
    localparam logic [7:0] CTRL_RESERVED_VAL = 8'h00;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int CHAN_LSB      = 0;
    localparam int CHAN_W        = 3;
    localparam int BUSY_BIT      = 3;
    localparam int DONE_BIT      = 4;
    localparam int EXT_EN_BIT    = 5;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic [2:0] CHAN_RST   = 3'h0;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam int         CONV_MACHINE_CYCLES = 24;
    localparam int         CNT_W      = 5;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CONVERT,
        ST_FINISH
    } conv_state_e;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
    } sfr_write_s;

endpackage

// *** design/adc_conversion_control.sv ***
`timescale 1ns/100ps
`default_nettype none

module adc_conversion_control #(
    parameter int CONV_CYCLES = adc_ctrl_pkg::CONV_MACHINE_CYCLES
) (
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    input  wire adc_ctrl_pkg::sfr_write_s sfr_wr_i,
    input  wire logic                     ext_conv_start_pin_i,
    input  wire logic                     idle_mode_i,
    input  wire logic                     power_down_i,
    input  wire logic [7:0]               adc_sample_i,
    output logic [7:0]                    conv_control_reg_o,
    output logic [7:0]                    conv_result_reg_o,
    output logic [2:0]                    channel_select_o,
    output logic                          converting_o,
    output logic                          conv_irq_o
);
    import adc_ctrl_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]       ext_sync;
        conv_state_e      state;
        logic [CNT_W-1:0] count;
        logic             conv_done_flag;
        logic             ext_start_enable;
        logic [2:0]       channel_select;
        logic [7:0]       result;
    } ctrl_state_s;

    localparam logic [CNT_W-1:0] LAST_COUNT = CNT_W'(CONV_CYCLES - 1);

    ctrl_state_s state_ff;
    ctrl_state_s nxt_state;

    logic ctrl_write;
    logic conv_start_busy;
    logic done_after_write;
    logic sw_start;
    logic ext_start;
    logic low_power;

    always_comb begin
        ctrl_write      = sfr_wr_i.wr && (sfr_wr_i.addr == CTRL_REG_ADDR);
        conv_start_busy = (state_ff.state != ST_IDLE);
        low_power       = idle_mode_i || power_down_i;
        // software may clear the flag only; writing one keeps it
        done_after_write = state_ff.conv_done_flag
                           && !(ctrl_write && !sfr_wr_i.wdata[DONE_BIT]);
        sw_start  = ctrl_write && sfr_wr_i.wdata[BUSY_BIT];
        // ext_sync[0] feeds only ext_sync[1]; edge uses stages 1 and 2
        ext_start = state_ff.ext_start_enable
                    && state_ff.ext_sync[1] && !state_ff.ext_sync[2];
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.ext_sync = {state_ff.ext_sync[1:0], ext_conv_start_pin_i};

        if (ctrl_write) begin
            nxt_state.ext_start_enable = sfr_wr_i.wdata[EXT_EN_BIT];
            if (!state_ff.conv_done_flag && !conv_start_busy) begin
                nxt_state.channel_select = sfr_wr_i.wdata[CHAN_LSB +: CHAN_W];
            end
        end
        nxt_state.conv_done_flag = done_after_write;

        unique case (state_ff.state)
            ST_IDLE: begin
                // a clear-and-start in one write is honoured on the old channel
                if ((sw_start || ext_start) && !done_after_write && !low_power) begin
                    nxt_state.state = ST_CONVERT;
                    nxt_state.count = '0;
                end
            end
            ST_CONVERT: begin
                // further starts are simply not looked at here
                if (low_power) begin
                    nxt_state.state = ST_IDLE;
                end else if (state_ff.count == LAST_COUNT) begin
                    nxt_state.state          = ST_FINISH;
                    nxt_state.conv_done_flag = 1'b1;
                    nxt_state.result         = adc_sample_i;
                end else begin
                    nxt_state.count = state_ff.count + CNT_W'(1);
                end
            end
            ST_FINISH: begin
                // busy overlaps done for this single cycle only
                nxt_state.state = ST_IDLE;
            end
        endcase
        // result only loads on the completion edge, never while done is set
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff.ext_sync         <= 3'h0;
            state_ff.state            <= ST_IDLE;
            state_ff.count            <= '0;
            state_ff.conv_done_flag   <= 1'b0;
            state_ff.ext_start_enable <= 1'b0;
            state_ff.channel_select   <= CHAN_RST;
            state_ff.result           <= RESULT_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb begin
        conv_control_reg_o = CTRL_RESERVED_VAL;
        conv_control_reg_o[EXT_EN_BIT] = state_ff.ext_start_enable;
        conv_control_reg_o[DONE_BIT]   = state_ff.conv_done_flag;
        conv_control_reg_o[BUSY_BIT]   = conv_start_busy;
        conv_control_reg_o[CHAN_LSB +: CHAN_W] = state_ff.channel_select;
    end

    assign conv_result_reg_o = state_ff.result;
    assign channel_select_o  = state_ff.channel_select;
    assign converting_o      = (state_ff.state == ST_CONVERT);
    assign conv_irq_o        = state_ff.conv_done_flag;

endmodule

`default_nettype wire

// *** tb/adc_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----
// converter core: every channel yields its own code
// ----
module adc_core_model (
    input  wire logic [2:0] chan_i,
    output logic      [7:0] sample_o
);
    assign sample_o = {~chan_i, 2'b10, chan_i};
endmodule
`default_nettype wire

// *** tb/adc_conversion_control_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_checker #(
    parameter int CONV_CYCLES = 24
) (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       idle_mode_i,
    input wire logic       power_down_i,
    input wire logic [7:0] adc_sample_i,
    input wire logic [7:0] conv_control_reg_o,
    input wire logic [7:0] conv_result_reg_o,
    input wire logic [2:0] channel_select_o,
    input wire logic       conv_irq_o
);
    wire logic [7:0] ctl = conv_control_reg_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----
    // properties
    // ----
    property p_rsv; ctl[7:6] == 2'b00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_ovl; ctl[4] && ctl[3] |=> !ctl[3]; endproperty
    a_ovl: assert property (p_ovl) else $error("done and busy overlap too long");
    property p_len; $rose(ctl[4]) |-> $past(ctl[3], CONV_CYCLES) && !$past(ctl[3], CONV_CYCLES + 1); endproperty
    a_len: assert property (p_len) else $error("conversion length wrong");
    property p_hold; ctl[4] && $past(ctl[4]) |-> $stable(conv_result_reg_o); endproperty
    a_hold: assert property (p_hold) else $error("result moved while done");
    property p_chan; !$stable(channel_select_o) |-> $past(ctl[4:3]) == 2'b00; endproperty
    a_chan: assert property (p_chan) else $error("channel changed while blocked");
    property p_fall; $fell(ctl[3]) |-> $past(ctl[4]) || $past(idle_mode_i) || $past(power_down_i); endproperty
    a_fall: assert property (p_fall) else $error("busy dropped early");
    property p_abort; ctl[3] && !ctl[4] && (idle_mode_i || power_down_i) |=> ctl[4:3] == 2'b00; endproperty
    a_abort: assert property (p_abort) else $error("low power did not abort");
    property p_res; $rose(ctl[4]) |-> conv_result_reg_o == $past(adc_sample_i); endproperty
    a_res: assert property (p_res) else $error("result not the sample");
    property p_irq; conv_irq_o == ctl[4]; endproperty
    a_irq: assert property (p_irq) else $error("irq differs from done");
endmodule
bind adc_conversion_control adc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES)) i_chk (.*);
`default_nettype wire

// *** tb/adc_conversion_control_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_control_tb;
    import adc_ctrl_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       pin = 1'b0;
    logic [1:0] low_pwr = 2'b00;
    sfr_write_s sfr_wr = '{CTRL_REG_ADDR, 1'b0, 8'h00};
    logic [7:0] sample, ctl, result;
    logic [2:0] chan;
    logic       irq;
    logic       conv;
    int         err_count = 0, compares = 0, n;
    adc_core_model i_core (.chan_i(chan), .sample_o(sample));
    adc_conversion_control i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_wr_i(sfr_wr),
        .ext_conv_start_pin_i(pin), .idle_mode_i(low_pwr[1]), .power_down_i(low_pwr[0]),
        .adc_sample_i(sample), .conv_control_reg_o(ctl), .conv_result_reg_o(result),
        .channel_select_o(chan), .converting_o(conv), .conv_irq_o(irq));
    always #2 clk_i = ~clk_i;
    // ----
    // tasks
    // ----
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        sfr_wr.wr = 1'b1;
        sfr_wr.wdata = d;
        @(negedge clk_i);
        sfr_wr.wr = 1'b0;
        @(negedge clk_i);
    endtask
    // n counts edges until done; a write may land at edge 'at' mid-run
    task automatic run(input int at, input logic [7:0] d);
        n = 0;
        while ((n < 2 || ctl[4] !== 1'b1) && n < 60) begin
            sfr_wr.wr = (n == at);
            sfr_wr.wdata = d;
            @(negedge clk_i);
            n++;
        end
        // strobe is already low here; lowering it again would clash with a following wr
    endtask
    task automatic print_verdict();
        $display("checks %0d bad %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #20000;
        err_count++;
        print_verdict();
    end
    // ----
    // tests
    // ----
    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1'b1;
        check("rst ctl", ctl, 8'h00);
        check("rst res", result, 8'h00);
        for (int c = 0; c < 8; c++) begin
            run(0, 8'hC8 | c[7:0]);
            check("time", n[7:0], 8'h19);
            check("both", {irq, ctl[6:0]}, 8'h98 | c[7:0]);
            check("cend", {7'h00, conv}, 8'h00);
            check("res", result, {~c[2:0], 2'b10, c[2:0]});
            wr(8'h1F ^ c[7:0]);
            check("hold", ctl, 8'h10 | c[7:0]);
            wr(8'h00);
            check("clr", ctl, c[7:0]);
        end
        $display("end channels");
        wr(8'h00);
        pin = 1'b1;
        repeat (4) @(negedge clk_i);
        check("noext", ctl, 8'h00);
        pin = 1'b0;
        repeat (3) @(negedge clk_i);
        wr(8'h20);
        pin = 1'b1;
        run(10, 8'h2B);
        check("ext", n[7:0], 8'h1B);
        check("ch", {5'h00, chan}, 8'h00);
        low_pwr = 2'b10;
        pin = 1'b0;
        repeat (3) @(negedge clk_i);
        check("keep", ctl, 8'h30);
        check("kres", result, 8'hF0);
        low_pwr = 2'b00;
        run(0, 8'h0D);
        check("restart", n[7:0], 8'h19);
        check("same", ctl, 8'h18);
        $display("end external");
        wr(8'h00);
        for (int k = 1; k < 3; k++) begin
            wr(8'h08);
            repeat (5) @(negedge clk_i);
            check("conv", {7'h00, conv}, 8'h01);
            low_pwr = k[1:0];
            @(negedge clk_i);
            low_pwr = 2'b00;
            check("abort", ctl, 8'h00);
        end
        $display("end low power");
        print_verdict();
    end
endmodule
`default_nettype wire
